// file: usb_irq_pkg.sv
// Constants, register map and field layout of the USB interrupt source and gate registers
package usb_irq_pkg;

  localparam int          REG_W   = 16;
  localparam int          ADDR_W  = 8;

  // Byte offsets, one aligned word per register
  localparam logic [7:0]  RAW_EP_OFS    = 8'h00;
  localparam logic [7:0]  RAW_CORE_OFS  = 8'h04;
  localparam logic [7:0]  FORCE_EP_OFS  = 8'h08;
  localparam logic [7:0]  FORCE_CORE_OFS = 8'h0C;
  localparam logic [7:0]  ACK_EP_OFS    = 8'h10;
  localparam logic [7:0]  ACK_CORE_OFS  = 8'h14;
  localparam logic [7:0]  GATE_EP_OFS   = 8'h18;
  localparam logic [7:0]  GATE_CORE_OFS = 8'h1C;
  localparam logic [7:0]  GATED_EP_OFS  = 8'h20;
  localparam logic [7:0]  GATED_CORE_OFS = 8'h24;

  // Field positions in the endpoint register, then the endpoint and core event counts
  localparam int          EP_RX_LSB     = 9;
  localparam int          EP_TX_LSB     = 1;
  localparam int          EP_CTRL_BIT   = 0;
  localparam int          EP_NUM        = 4;
  localparam int          CORE_NUM      = 9;

  // Implemented bits; everything else is reserved
  localparam logic [15:0] EP_VALID      = 16'h1E1F;
  localparam logic [15:0] CORE_VALID    = 16'h01FF;

  // Values after reset
  localparam logic [15:0] RAW_RESET     = 16'h0000;
  localparam logic [15:0] GATE_RESET    = 16'h0000;

endpackage : usb_irq_pkg

// file: usb_irq_source_mask_regs.sv
// Raw source, force, ack, gate and gated status registers for USB core events
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module usb_irq_source_mask_regs
  import usb_irq_pkg::*;
#(
  parameter int EP_COUNT   = EP_NUM,
  parameter int CORE_COUNT = CORE_NUM
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [REG_W-1:0]  i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [REG_W-1:0]  o_rdata,
  input  wire logic [3:0]        i_ep_receive_event,
  input  wire logic [3:0]        i_ep_transmit_event,
  input  wire logic              i_control_endpoint_event,
  input  wire logic [8:0]        i_core_event,
  output logic                   o_irq
);

  // Field layout is fixed; other counts cannot be served
  if (EP_COUNT != EP_NUM || CORE_COUNT != CORE_NUM) begin : g_bad_param
    $error("usb_irq_source_mask_regs: endpoint or core event count not supported");
  end

  // Register selects, one per decoded offset
  logic                sel_raw_ep;
  logic                sel_raw_core;
  logic                sel_force_ep;
  logic                sel_force_core;
  logic                sel_ack_ep;
  logic                sel_ack_core;
  logic                sel_gate_ep;
  logic                sel_gate_core;
  logic                sel_gated_ep;
  logic                sel_gated_core;

  // Write-one vectors, all zero unless that register is written this cycle
  logic [REG_W-1:0]    force_ep_bits;
  logic [REG_W-1:0]    force_core_bits;
  logic [REG_W-1:0]    ack_ep_bits;
  logic [REG_W-1:0]    ack_core_bits;

  // Event and set images in register layout
  logic [REG_W-1:0]    ep_events;
  logic [REG_W-1:0]    core_events;
  logic [REG_W-1:0]    ep_set;
  logic [REG_W-1:0]    core_set;

  // Next register images before they are split into fields
  logic [REG_W-1:0]    raw_ep_next;
  logic [REG_W-1:0]    raw_core_next;

  // Source fields, stored apart so each field has its own update
  logic [EP_NUM-1:0]   ep_rx_q;
  logic [EP_NUM-1:0]   ep_rx_d;
  logic [EP_NUM-1:0]   ep_tx_q;
  logic [EP_NUM-1:0]   ep_tx_d;
  logic                ep_ctrl_q;
  logic                ep_ctrl_d;
  logic [CORE_NUM-1:0] core_q;
  logic [CORE_NUM-1:0] core_d;

  // Gate fields
  logic [EP_NUM-1:0]   gate_rx_q;
  logic [EP_NUM-1:0]   gate_tx_q;
  logic                gate_ctrl_q;
  logic [CORE_NUM-1:0] gate_core_q;

  // Assembled register images
  logic [REG_W-1:0]    raw_ep;
  logic [REG_W-1:0]    raw_core;
  logic [REG_W-1:0]    gate_ep;
  logic [REG_W-1:0]    gate_core;
  logic [REG_W-1:0]    gated_ep;
  logic [REG_W-1:0]    gated_core;

  // Gated fields
  logic [EP_NUM-1:0]   gated_rx;
  logic [EP_NUM-1:0]   gated_tx;
  logic                gated_ctrl;
  logic [CORE_NUM-1:0] gated_core_bits;

  // Read path and interrupt
  logic                rd_raw_ep;
  logic                rd_raw_core;
  logic                pending_ep;
  logic                pending_core;
  logic [REG_W-1:0]    rdata_d;
  logic [REG_W-1:0]    rdata_q;
  logic                irq_q;

  // Sticky update: a set from an event or a force wins over a same-cycle ack
  function automatic logic [REG_W-1:0] sticky_next(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] set_bits,
    input logic [REG_W-1:0] clr_bits
  );
    sticky_next = (cur & ~clr_bits) | set_bits;
  endfunction : sticky_next

  // Exact offset match; partial decoding would alias the unmapped holes
  function automatic logic addr_is(
    input logic [ADDR_W-1:0] a,
    input logic [7:0]        ofs
  );
    addr_is = (a == ofs);
  endfunction : addr_is

  // Places the endpoint fields at their positions; reserved bits stay zero
  function automatic logic [REG_W-1:0] ep_image(
    input logic [EP_NUM-1:0] rx,
    input logic [EP_NUM-1:0] tx,
    input logic              ctrl
  );
    ep_image                      = '0;
    ep_image[EP_RX_LSB +: EP_NUM] = rx;
    ep_image[EP_TX_LSB +: EP_NUM] = tx;
    ep_image[EP_CTRL_BIT]         = ctrl;
  endfunction : ep_image

  // Places the core events in the low bits; the upper bits are reserved
  function automatic logic [REG_W-1:0] core_image(
    input logic [CORE_NUM-1:0] bits
  );
    core_image                = '0;
    core_image[CORE_NUM-1:0]  = bits;
  endfunction : core_image

  // The valid patterns must agree with the field positions
  if (EP_VALID != ep_image('1, '1, 1'b1) || CORE_VALID != core_image('1)) begin : g_bad_layout
    $error("usb_irq_source_mask_regs: valid bit patterns disagree with field layout");
  end

  // Offsets are eight bits wide; a narrower bus would alias them
  if (ADDR_W != 8) begin : g_bad_addr
    $error("usb_irq_source_mask_regs: address width not supported");
  end

  // Registers must be wide enough for the widest field
  if (REG_W < EP_RX_LSB + EP_NUM || REG_W < CORE_NUM) begin : g_bad_width
    $error("usb_irq_source_mask_regs: register width too small");
  end

  // One select per offset; anything else decodes to no register
  always_comb begin
    sel_raw_ep     = 1'b0;
    sel_raw_core   = 1'b0;
    sel_force_ep   = 1'b0;
    sel_force_core = 1'b0;
    sel_ack_ep     = 1'b0;
    sel_ack_core   = 1'b0;
    sel_gate_ep    = 1'b0;
    sel_gate_core  = 1'b0;
    sel_gated_ep   = 1'b0;
    sel_gated_core = 1'b0;

    if (addr_is(i_addr, RAW_EP_OFS)) begin
      sel_raw_ep = 1'b1;
    end else if (addr_is(i_addr, RAW_CORE_OFS)) begin
      sel_raw_core = 1'b1;
    end else if (addr_is(i_addr, FORCE_EP_OFS)) begin
      sel_force_ep = 1'b1;
    end else if (addr_is(i_addr, FORCE_CORE_OFS)) begin
      sel_force_core = 1'b1;
    end else if (addr_is(i_addr, ACK_EP_OFS)) begin
      sel_ack_ep = 1'b1;
    end else if (addr_is(i_addr, ACK_CORE_OFS)) begin
      sel_ack_core = 1'b1;
    end else if (addr_is(i_addr, GATE_EP_OFS)) begin
      sel_gate_ep = 1'b1;
    end else if (addr_is(i_addr, GATE_CORE_OFS)) begin
      sel_gate_core = 1'b1;
    end else if (addr_is(i_addr, GATED_EP_OFS)) begin
      sel_gated_ep = 1'b1;
    end else if (addr_is(i_addr, GATED_CORE_OFS)) begin
      sel_gated_core = 1'b1;
    end
  end

  // Only bits written as one reach the update; reserved bits are cut by the valid pattern
  always_comb begin
    force_ep_bits   = '0;
    force_core_bits = '0;

    if (i_wr && sel_force_ep) begin
      force_ep_bits = i_wdata & EP_VALID;
    end
    if (i_wr && sel_force_core) begin
      force_core_bits = i_wdata & CORE_VALID;
    end
  end

  // Acks use the same masking, so a reserved bit can never be touched
  always_comb begin
    ack_ep_bits   = '0;
    ack_core_bits = '0;

    if (i_wr && sel_ack_ep) begin
      ack_ep_bits = i_wdata & EP_VALID;
    end
    if (i_wr && sel_ack_core) begin
      ack_core_bits = i_wdata & CORE_VALID;
    end
  end

  // Event lines come from the core on this clock, so no synchroniser is needed
  always_comb begin
    ep_events   = ep_image(i_ep_receive_event, i_ep_transmit_event, i_control_endpoint_event);
    core_events = core_image(i_core_event);
  end

  // Events and forces share one set path
  always_comb begin
    ep_set        = ep_events | force_ep_bits;
    core_set      = core_events | force_core_bits;
    raw_ep_next   = sticky_next(raw_ep, ep_set, ack_ep_bits);
    raw_core_next = sticky_next(raw_core, core_set, ack_core_bits);
    ep_rx_d       = raw_ep_next[EP_RX_LSB +: EP_NUM];
    ep_tx_d       = raw_ep_next[EP_TX_LSB +: EP_NUM];
    ep_ctrl_d     = raw_ep_next[EP_CTRL_BIT];
    core_d        = raw_core_next[CORE_NUM-1:0];
  end

  // Receive sources; raw sources never look at the gates
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ep_rx_q <= RAW_RESET[EP_RX_LSB +: EP_NUM];
    end else begin
      ep_rx_q <= ep_rx_d;
    end
  end

  // Transmit sources
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ep_tx_q <= RAW_RESET[EP_TX_LSB +: EP_NUM];
    end else begin
      ep_tx_q <= ep_tx_d;
    end
  end

  // Control endpoint source
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ep_ctrl_q <= RAW_RESET[EP_CTRL_BIT];
    end else begin
      ep_ctrl_q <= ep_ctrl_d;
    end
  end

  // Core event sources
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      core_q <= RAW_RESET[CORE_NUM-1:0];
    end else begin
      core_q <= core_d;
    end
  end

  // Receive gates; plain read/write, same layout as the sources
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_rx_q <= GATE_RESET[EP_RX_LSB +: EP_NUM];
    end else if (i_wr && sel_gate_ep) begin
      gate_rx_q <= i_wdata[EP_RX_LSB +: EP_NUM];
    end
  end

  // Transmit gates
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_tx_q <= GATE_RESET[EP_TX_LSB +: EP_NUM];
    end else if (i_wr && sel_gate_ep) begin
      gate_tx_q <= i_wdata[EP_TX_LSB +: EP_NUM];
    end
  end

  // Control endpoint gate
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_ctrl_q <= GATE_RESET[EP_CTRL_BIT];
    end else if (i_wr && sel_gate_ep) begin
      gate_ctrl_q <= i_wdata[EP_CTRL_BIT];
    end
  end

  // Core event gates
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_core_q <= GATE_RESET[CORE_NUM-1:0];
    end else if (i_wr && sel_gate_core) begin
      gate_core_q <= i_wdata[CORE_NUM-1:0];
    end
  end

  // Raw images for read back and for the next-state update
  always_comb begin
    raw_ep   = ep_image(ep_rx_q, ep_tx_q, ep_ctrl_q);
    raw_core = core_image(core_q);
  end

  // Gate images for read back
  always_comb begin
    gate_ep   = ep_image(gate_rx_q, gate_tx_q, gate_ctrl_q);
    gate_core = core_image(gate_core_q);
  end

  // Each gate bit masks the source bit at its own position
  always_comb begin
    gated_rx   = ep_rx_q & gate_rx_q;
    gated_tx   = ep_tx_q & gate_tx_q;
    gated_ctrl = ep_ctrl_q & gate_ctrl_q;
  end

  assign gated_core_bits = core_q & gate_core_q;

  // Gated images for read back
  always_comb begin
    gated_ep   = ep_image(gated_rx, gated_tx, gated_ctrl);
    gated_core = core_image(gated_core_bits);
  end

  // Any gated bit keeps the interrupt pending
  assign pending_ep   = |gated_ep;
  assign pending_core = |gated_core;

  // Force and ack offsets read back the live raw register
  assign rd_raw_ep   = sel_raw_ep || sel_force_ep || sel_ack_ep;
  assign rd_raw_core = sel_raw_core || sel_force_core || sel_ack_core;

  // Read decode; reads have no side effects, unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (rd_raw_ep) begin
      rdata_d = raw_ep;
    end else if (rd_raw_core) begin
      rdata_d = raw_core;
    end else if (sel_gate_ep) begin
      rdata_d = gate_ep;
    end else if (sel_gate_core) begin
      rdata_d = gate_core;
    end else if (sel_gated_ep) begin
      rdata_d = gated_ep;
    end else if (sel_gated_core) begin
      rdata_d = gated_core;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  // Registered level; one cycle behind the gated status, traded for a clean output
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pending_ep || pending_core;
    end
  end

  // Both outputs come straight from flip-flops
  assign o_rdata = rdata_q;
  assign o_irq   = irq_q;

endmodule : usb_irq_source_mask_regs

// file: usb_irq_sva.sv
// Port assertions for the USB interrupt source registers
`timescale 1ns/1ps
module usb_irq_sva (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [3:0]  i_ep_receive_event,
  input wire logic [3:0]  i_ep_transmit_event,
  input wire logic        i_control_endpoint_event,
  input wire logic [8:0]  i_core_event,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire ev = |{i_ep_receive_event, i_ep_transmit_event, i_control_endpoint_event, i_core_event};
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("stray data");
  a_unmapped_zero: assert property (i_rd && i_addr > 8'h24 |=> o_rdata == 16'h0000) else $error("unmapped");
  a_ep_reserved: assert property (i_rd && !i_addr[2] |=> (o_rdata & 16'hE1E0) == 16'h0000) else $error("ep rsvd");
  a_core_reserved: assert property (i_rd && i_addr[2] |=> o_rdata[15:9] == 7'h00) else $error("core rsvd");
  a_event_sets: assert property (i_ep_receive_event[0] ##1 (i_rd && i_addr == 8'h00) |=> o_rdata[9])
    else $error("event lost");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_wr, 2) || $past(ev, 2)) else $error("irq rose");
  a_irq_drop: assert property ($fell(o_irq) |-> $past(i_wr, 2)) else $error("irq fell");
  a_force_reads: assert property ((i_rd && i_addr == 8'h00 && !ev)
    ##1 (i_rd && i_addr inside {8'h08, 8'h10}) |=> $stable(o_rdata)) else $error("force read");
  a_ack_clears: assert property ((i_wr && i_addr == 8'h14 && i_wdata[8:0] == 9'h1FF && !ev)
    ##1 (i_rd && i_addr == 8'h04) |=> o_rdata == 16'h0000) else $error("ack missed");
  c_rise: cover property ($rose(o_irq));
  c_fall: cover property ($fell(o_irq));
  c_gated: cover property (i_rd && i_addr == 8'h24);
endmodule : usb_irq_sva
bind usb_irq_source_mask_regs usb_irq_sva usb_irq_sva_inst (.*);

// file: usb_core_model.sv
// USB core model raising endpoint and core events as one-cycle pulses
`timescale 1ns/1ps
module usb_core_model (
  input  wire logic        i_fire,
  input  wire logic [17:0] i_pat,
  output logic      [3:0]  o_rx,
  output logic      [3:0]  o_tx,
  output logic             o_ctrl,
  output logic      [8:0]  o_core
);
  // Endpoint and core events together; all outputs are zero while i_fire is low
  assign {o_core, o_ctrl, o_tx, o_rx} = i_fire ? i_pat : 18'h00000;
endmodule : usb_core_model

// file: testbench.sv
// Bench comparing the interrupt source registers with a behavioural model
`timescale 1ns/1ps
module testbench;
  import usb_irq_pkg::*;
  logic        i_clk, i_resetn, i_wr, i_rd, fire, o_irq, ctrl, pend;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [17:0] pat;
  logic [31:0] rnd;
  logic [3:0]  rx, tx;
  logic [8:0]  core;
  int          bad_count, checks, seed, raw_ep, raw_core, gate_ep, gate_core, exp, last_irq, n;
  usb_core_model usb_core_model_inst (.i_fire(fire), .i_pat(pat), .o_rx(rx), .o_tx(tx), .o_ctrl(ctrl), .o_core(core));
  usb_irq_source_mask_regs usb_irq_source_mask_regs_inst (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_ep_receive_event(rx), .i_ep_transmit_event(tx), .i_control_endpoint_event(ctrl),
    .i_core_event(core), .o_irq);
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  // One bus cycle plus events; read data and irq are checked a cycle late, as they are registered
  task cyc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d, input logic [17:0] ev);
    int ep, clr_ep, clr_core, cs;
    @(posedge i_clk);
    {i_wr, i_rd, i_addr, i_wdata, fire, pat} <= {w, r, a, d, |ev, ev};
    @(negedge i_clk);
    if (pend) chk(o_rdata, exp[15:0]);
    chk({15'h0000, o_irq}, last_irq[15:0]);
    last_irq = |((raw_ep & gate_ep) | (raw_core & gate_core));
    pend = r;
    case (a)
      8'h00, 8'h08, 8'h10: exp = raw_ep;
      8'h04, 8'h0C, 8'h14: exp = raw_core;
      8'h18: exp = gate_ep;
      8'h1C: exp = gate_core;
      8'h20: exp = raw_ep & gate_ep;
      8'h24: exp = raw_core & gate_core;
      default: exp = 0;
    endcase
    ep = {ev[3:0], 4'h0, ev[7:4], ev[8]};
    cs = ev[17:9];
    clr_ep = 0;
    clr_core = 0;
    if (w) begin
      case (a)
        8'h08: ep = ep | (d & EP_VALID);
        8'h0C: cs = cs | (d & CORE_VALID);
        8'h10: clr_ep = d;
        8'h14: clr_core = d;
        8'h18: gate_ep = d & EP_VALID;
        8'h1C: gate_core = d & CORE_VALID;
        default: ;
      endcase
    end
    // A set in the same cycle as an ack wins
    raw_ep = (raw_ep & ~clr_ep) | ep;
    raw_core = (raw_core & ~clr_core) | cs;
  endtask : cyc
  task close_out;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    seed = 87828;
    {i_resetn, i_wr, i_rd, i_addr, i_wdata, fire, pat, pend} = '0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    cyc(0, 0, 8'h00, 16'h0000, 18'h001FF);
    cyc(0, 1, 8'h00, 16'h0000, 18'h00000);
    cyc(0, 1, 8'h08, 16'h0000, 18'h00000);
    cyc(1, 0, 8'h1C, 16'hFFFF, 18'h3FE00);
    cyc(0, 1, 8'h24, 16'h0000, 18'h00000);
    cyc(1, 0, 8'h14, 16'hFFFF, 18'h00000);
    cyc(0, 1, 8'h04, 16'h0000, 18'h00000);
    for (n = 0; n < 3000; n++) begin
      rnd = $random(seed);
      cyc(rnd[1:0] == 2'h1, rnd[1:0] == 2'h2, 8'((rnd[5:2] % 11) * 4), 16'($random(seed)),
        rnd[8:6] == 3'h0 ? 18'($random(seed)) : 18'h00000);
    end
    cyc(0, 0, 8'h00, 16'h0000, 18'h00000);
    // Mid-run reset: the endpoint gates and sources must come back cleared
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    {raw_ep, raw_core, gate_ep, gate_core, last_irq, pend} = '0;
    cyc(0, 1, 8'h18, 16'h0000, 18'h00000);
    cyc(1, 0, 8'h18, 16'hFFFF, 18'h00000);
    cyc(0, 0, 8'h00, 16'h0000, 18'h00001);
    cyc(0, 1, 8'h20, 16'h0000, 18'h00000);
    cyc(0, 0, 8'h00, 16'h0000, 18'h00000);
    cyc(0, 0, 8'h00, 16'h0000, 18'h00000);
    close_out();
  end
endmodule : testbench
